//--- wdnr_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdnr_top #(
  parameter int unsigned CNT_W = wdnr_pkg::CNT_W,
  parameter int unsigned DIV   = wdnr_pkg::OSC_DIV
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_nrst,
  input  wire logic                        i_low_speed_osc,
  input  wire logic [wdnr_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [wdnr_pkg::DATA_W-1:0] i_avs_writedata,
  input  wire logic [wdnr_pkg::BE_W-1:0]   i_avs_byteenable,
  output logic [wdnr_pkg::DATA_W-1:0]      o_avs_readdata,
  output logic                             o_avs_waitrequest,
  output logic                             o_nmi,
  output logic                             o_cpu_reset
);

  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // ***************************************************
  // Declarations
  // ***************************************************
  wdnr_pkg::wdnr_req_t            req;
  wdnr_pkg::wdnr_acc_t            acc;
  logic [wdnr_pkg::REG_W-1:0]     rdata;
  logic                           tick;
  logic                           ctl_wr;
  logic                           st_wr;
  logic                           restart_wr;
  logic                           running;
  logic                           overflow;
  logic [wdnr_pkg::RUN_W-1:0]     run_field_ff;
  logic                           mode_ff;
  logic                           ovf_status_ff;
  logic [CNT_W-1:0]               cnt_ff;
  logic                           nmi_ff;
  logic                           cpu_reset_ff;

  // ***************************************************
  // Bus slave and tick source
  // ***************************************************
  assign req.read       = i_avs_read;
  assign req.write      = i_avs_write;
  assign req.address    = i_avs_address;
  assign req.writedata  = i_avs_writedata;
  assign req.byteenable = i_avs_byteenable;

  wdnr_avs u_avs (
    .i_ref_clk     (i_ref_clk),
    .i_nrst        (i_nrst),
    .i_req         (req),
    .i_rdata       (rdata),
    .o_waitrequest (o_avs_waitrequest),
    .o_readdata    (o_avs_readdata),
    .o_acc         (acc)
  );

  // Tick keeps coming in halt, stops in sleep with the oscillator
  wdnr_tick #(
    .DIV (DIV)
  ) u_tick (
    .i_ref_clk       (i_ref_clk),
    .i_nrst          (i_nrst),
    .i_low_speed_osc (i_low_speed_osc),
    .o_tick          (tick)
  );

  // ***************************************************
  // Register decode
  // ***************************************************
  // two byte registers
  assign ctl_wr     = acc.wr_en && (acc.address == wdnr_pkg::CTL_ADDR);
  assign st_wr      = acc.wr_en && (acc.address == wdnr_pkg::ST_ADDR);
  assign restart_wr = ctl_wr && acc.wdata[wdnr_pkg::RESTART_BIT];

  // Read mux; restart and reserved bits read zero
  // restart reads zero
  always_comb
  begin
    rdata = '0;
    if (acc.address == wdnr_pkg::CTL_ADDR)
      rdata[wdnr_pkg::RUN_LSB +: wdnr_pkg::RUN_W] = run_field_ff;
    else if (acc.address == wdnr_pkg::ST_ADDR)
    begin
      rdata[wdnr_pkg::MODE_BIT] = mode_ff;
      rdata[wdnr_pkg::OVF_BIT]  = ovf_status_ff;
    end
  end

  // ***************************************************
  // Control registers
  // ***************************************************
  // stop key at reset
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      run_field_ff <= wdnr_pkg::RUN_STOP_KEY;
    else if (ctl_wr)
      run_field_ff <= acc.wdata[wdnr_pkg::RUN_LSB +: wdnr_pkg::RUN_W];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      mode_ff <= wdnr_pkg::MODE_NMI;
    else if (st_wr)
      mode_ff <= acc.wdata[wdnr_pkg::MODE_BIT];
  end

  // ***************************************************
  // Timeout counter
  // ***************************************************
  // run unless stop key
  assign running  = (run_field_ff != wdnr_pkg::RUN_STOP_KEY);
  assign overflow = tick && running && (cnt_ff == CNT_MAX) && !restart_wr;

  // Restart wins over a tick in the same cycle
  // stop keeps count
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      cnt_ff <= '0;
    else if (restart_wr)
      cnt_ff <= '0;
    else if (tick && running)
      cnt_ff <= cnt_ff + CNT_W'(1);
  end

  // ***************************************************
  // Status and outputs toward the CPU
  // ***************************************************
  // Restart clear wins; a restart write blocks overflow in that cycle
  // set on overflow
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      ovf_status_ff <= 1'h0;
    else if (overflow)
      ovf_status_ff <= 1'h1;
    else if (restart_wr)
      ovf_status_ff <= 1'h0;
  end

  // One-cycle NMI or reset request on overflow
  // action on timeout
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      nmi_ff       <= 1'h0;
      cpu_reset_ff <= 1'h0;
    end
    else
    begin
      nmi_ff       <= overflow && (mode_ff == wdnr_pkg::MODE_NMI);
      cpu_reset_ff <= overflow && (mode_ff == wdnr_pkg::MODE_RESET);
    end
  end

  assign o_nmi       = nmi_ff;
  assign o_cpu_reset = cpu_reset_ff;

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  AST_NMI_ON_OVF: assert property (
    overflow && !mode_ff |=> nmi_ff && !cpu_reset_ff && ovf_status_ff)
    else $error("nmi missing after overflow");

  AST_RESET_ON_OVF: assert property (
    overflow && mode_ff |=> cpu_reset_ff && !nmi_ff && ovf_status_ff)
    else $error("reset missing after overflow");

  AST_TICK_ADVANCE: assert property (
    tick && running && !restart_wr |=> cnt_ff == CNT_W'($past(cnt_ff) + 1))
    else $error("counter did not advance on tick");

  AST_STOP_HOLDS: assert property (
    !running && !restart_wr |=> cnt_ff == $past(cnt_ff))
    else $error("stopped counter changed");

  AST_NO_TICK_HOLDS: assert property (
    !tick && !restart_wr |=> $stable(cnt_ff))
    else $error("counter moved without tick");

  AST_RESTART_CLEARS: assert property (
    restart_wr |=> cnt_ff == '0 && !ovf_status_ff && !nmi_ff && !cpu_reset_ff)
    else $error("restart did not clear counter and status");

  AST_ZERO_WRITE_NOOP: assert property (
    ctl_wr && !acc.wdata[wdnr_pkg::RESTART_BIT] && !running
    |=> cnt_ff == $past(cnt_ff))
    else $error("zero restart write changed counter");

  AST_STATUS_STICKY: assert property (
    ovf_status_ff && !restart_wr |=> ovf_status_ff)
    else $error("overflow status dropped without restart");

  AST_CTL_READBACK: assert property (
    acc.address == wdnr_pkg::CTL_ADDR |-> rdata[wdnr_pkg::REG_W-1:wdnr_pkg::RUN_W] == '0)
    else $error("restart or reserved bits read nonzero");

  AST_RUN_KEY_AFTER_RESET: assert property (
    $rose(i_nrst) |-> run_field_ff == wdnr_pkg::RUN_STOP_KEY)
    else $error("run field not at stop key after reset");

  AST_MODE_WRITE: assert property (
    st_wr |=> mode_ff == $past(acc.wdata[wdnr_pkg::MODE_BIT]))
    else $error("mode bit did not take written value");

  AST_OUTPUT_PULSE: assert property (
    nmi_ff || cpu_reset_ff |=> !nmi_ff && !cpu_reset_ff)
    else $error("overflow output longer than one cycle");

  // ***************************************************
  // Output, register and read-back checks
  // ***************************************************
  AST_NO_SPURIOUS_OUT: assert property (
    !overflow |=> !nmi_ff && !cpu_reset_ff)
    else $error("nmi or reset without overflow");

  AST_ONE_ACTION: assert property (
    !(nmi_ff && cpu_reset_ff))
    else $error("nmi and reset raised together");

  AST_MODE_HOLD: assert property (
    !st_wr |=> $stable(mode_ff))
    else $error("mode bit changed without a write");

  AST_RUN_WRITE: assert property (
    ctl_wr |=> run_field_ff == $past(acc.wdata[wdnr_pkg::RUN_LSB +: wdnr_pkg::RUN_W]))
    else $error("run field did not take written value");

  AST_RUN_HOLD: assert property (
    !ctl_wr |=> $stable(run_field_ff))
    else $error("run field changed without a write");

  AST_STOP_NO_OUT: assert property (
    !running |=> !nmi_ff && !cpu_reset_ff)
    else $error("stopped timer raised an output");

  AST_RUNNING_ZERO_WRITE: assert property (
    ctl_wr && !acc.wdata[wdnr_pkg::RESTART_BIT] && running && !tick
    |=> $stable(cnt_ff))
    else $error("zero restart write moved running counter");

  AST_STATUS_ONLY_ON_OVF: assert property (
    !ovf_status_ff && !overflow |=> !ovf_status_ff)
    else $error("overflow status set without overflow");

  AST_FULL_COUNT_FIRES: assert property (
    tick && running && cnt_ff == CNT_MAX && !restart_wr |=> nmi_ff || cpu_reset_ff)
    else $error("full counter did not fire while running");

  AST_ST_READBACK: assert property (
    acc.address == wdnr_pkg::ST_ADDR |-> rdata[wdnr_pkg::REG_W-1:wdnr_pkg::MODE_BIT+1] == '0)
    else $error("status reserved bits read nonzero");

  AST_WRAP_AFTER_FIRE: assert property (
    nmi_ff || cpu_reset_ff |-> $past(cnt_ff) == CNT_MAX && cnt_ff == '0)
    else $error("output not at counter carry out");

  COV_NMI: cover property (overflow && !mode_ff ##1 nmi_ff);
  COV_RESET: cover property (overflow && mode_ff ##1 cpu_reset_ff);
  COV_RESTART: cover property (restart_wr && running);
  COV_STOP_TICK: cover property (tick && !running);
  COV_START_NO_RESTART: cover property (ctl_wr && !running && !restart_wr ##1 running);

endmodule // wdnr_top
`default_nettype wire

//--- wdnr_pkg.sv
`default_nettype none
package wdnr_pkg;

  // ***************************************************
  // Bus geometry
  // ***************************************************
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;
  localparam int unsigned REG_W  = 8;

  // ***************************************************
  // Register indices and byte addresses (byte = 4 * index)
  // ***************************************************
  localparam logic [15:0]       CTL_INDEX = 16'h5040;
  localparam logic [15:0]       ST_INDEX  = 16'h5041;
  localparam logic [ADDR_W-1:0] CTL_ADDR  = {CTL_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] ST_ADDR   = {ST_INDEX, 2'h0};

  // ***************************************************
  // Field layout and reset values
  // ***************************************************
  localparam int unsigned RUN_LSB     = 0;
  localparam int unsigned RUN_W       = 4;
  localparam int unsigned RESTART_BIT = 4;
  localparam int unsigned OVF_BIT     = 0;
  localparam int unsigned MODE_BIT    = 1;
  localparam int unsigned LANE0_BIT   = 0;
  localparam logic [RUN_W-1:0] RUN_STOP_KEY = 4'ha;
  localparam logic             MODE_NMI     = 1'h0;
  localparam logic             MODE_RESET   = 1'h1;

  // ***************************************************
  // Timing: oscillator periods, divider and counter size
  // ***************************************************
  localparam int unsigned OSC_DIV             = 128;
  localparam int unsigned CNT_W               = 10;
  localparam int unsigned TIMEOUT_OSC_PERIODS = 131072;
  localparam int unsigned TIMEOUT_TICKS       = TIMEOUT_OSC_PERIODS / OSC_DIV;

  // ***************************************************
  // Carriers and bus slave states
  // ***************************************************
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } wdnr_req_t;

  typedef struct packed {
    logic              rd_en;
    logic              wr_en;
    logic [ADDR_W-1:0] address;
    logic [REG_W-1:0]  wdata;
  } wdnr_acc_t;

  typedef enum logic [1:0] {
    AVS_IDLE = 2'h1,
    AVS_ACK  = 2'h2
  } wdnr_avs_state_t;

endpackage
`default_nettype wire

//--- wdnr_tick.sv
`timescale 1ns/1ps
`default_nettype none
module wdnr_tick #(
  parameter int unsigned DIV = wdnr_pkg::OSC_DIV
) (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_low_speed_osc,
  output logic      o_tick
);

  localparam int unsigned DW = $clog2(DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic          osc_prev_ff;
  logic [DW-1:0] div_cnt_ff;
  logic          tick_ff;
  logic          osc_rise;

  // ***************************************************
  // Oscillator divider
  // ***************************************************
  assign osc_rise = i_low_speed_osc & ~osc_prev_ff;

  // Edge history of the oscillator input; follows the pin in reset so no false edge
  always_ff @(posedge i_ref_clk)
  begin
    osc_prev_ff <= i_low_speed_osc;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      div_cnt_ff <= '0;
      tick_ff    <= 1'h0;
    end
    else
    begin
      tick_ff <= osc_rise && (div_cnt_ff == DIV_LAST);
      if (osc_rise)
        div_cnt_ff <= (div_cnt_ff == DIV_LAST) ? '0 : div_cnt_ff + DW'(1);
    end
  end

  assign o_tick = tick_ff;

  AST_TICK_SINGLE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    tick_ff |=> !tick_ff)
    else $error("tick lasted more than one cycle");

endmodule // wdnr_tick
`default_nettype wire

//--- wdnr_avs.sv
`timescale 1ns/1ps
`default_nettype none
module wdnr_avs (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_nrst,
  input  wire wdnr_pkg::wdnr_req_t       i_req,
  input  wire logic [wdnr_pkg::REG_W-1:0] i_rdata,
  output logic                           o_waitrequest,
  output logic [wdnr_pkg::DATA_W-1:0]    o_readdata,
  output wdnr_pkg::wdnr_acc_t            o_acc
);

  wdnr_pkg::wdnr_avs_state_t state_ff;
  logic                      waitreq_ff;
  logic [wdnr_pkg::DATA_W-1:0] rdata_ff;
  logic                      req_on;

  assign req_on = i_req.read | i_req.write;

  // ***************************************************
  // One wait state per request
  // ***************************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      state_ff   <= wdnr_pkg::AVS_IDLE;
      waitreq_ff <= 1'h1;
    end
    else
    begin
      case (state_ff)
        wdnr_pkg::AVS_IDLE:
        begin
          if (req_on)
          begin
            state_ff   <= wdnr_pkg::AVS_ACK;
            waitreq_ff <= 1'h0;
          end
        end
        wdnr_pkg::AVS_ACK:
        begin
          state_ff   <= wdnr_pkg::AVS_IDLE;
          waitreq_ff <= 1'h1;
        end
        default:
        begin
          state_ff   <= wdnr_pkg::AVS_IDLE;
          waitreq_ff <= 1'h1;
        end
      endcase
    end
  end

  // Read data captured as the wait state ends, zero-extended
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      rdata_ff <= '0;
    else if (state_ff == wdnr_pkg::AVS_IDLE && i_req.read)
      rdata_ff <= {{(wdnr_pkg::DATA_W - wdnr_pkg::REG_W){1'h0}}, i_rdata};
  end

  // Access strobes act at the edge where waitrequest is low
  assign o_acc.rd_en   = (state_ff == wdnr_pkg::AVS_ACK) && i_req.read;
  assign o_acc.wr_en   = (state_ff == wdnr_pkg::AVS_ACK) && i_req.write &&
                         i_req.byteenable[wdnr_pkg::LANE0_BIT];
  assign o_acc.address = i_req.address;
  assign o_acc.wdata   = i_req.writedata[wdnr_pkg::REG_W-1:0];
  assign o_waitrequest = waitreq_ff;
  assign o_readdata    = rdata_ff;

endmodule // wdnr_avs
`default_nettype wire

//--- wdnr_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// CPU side: takes NMI and reset pulses
// ****************************************
module wdnr_cpu_model #(
  parameter int unsigned RST_LEN = 4
) (
  input  wire logic   i_ref_clk,
  input  wire logic   i_nmi,
  input  wire logic   i_cpu_reset,
  output logic        o_sys_nrst,
  output logic [15:0] o_nmi_cnt,
  output logic [15:0] o_rst_cnt
);
  logic [15:0] nmi_cnt_ff = 16'h0;
  logic [15:0] rst_cnt_ff = 16'h0;
  int          hold_ff    = 0;

  // Count NMI entries
  // halt wakeup
  always_ff @(posedge i_ref_clk)
  begin
    if (i_nmi)
      nmi_cnt_ff <= nmi_cnt_ff + 16'h1;
  end

  // Stretch a reset pulse into a chip-wide reset
  // reset clears status
  always_ff @(posedge i_ref_clk)
  begin
    if (i_cpu_reset)
    begin
      rst_cnt_ff <= rst_cnt_ff + 16'h1;
      hold_ff    <= RST_LEN;
    end
    else if (hold_ff > 0)
      hold_ff <= hold_ff - 1;
  end

  assign o_sys_nrst = (hold_ff == 0);
  assign o_nmi_cnt  = nmi_cnt_ff;
  assign o_rst_cnt  = rst_cnt_ff;
endmodule // wdnr_cpu_model
`default_nettype wire

//--- watchdog_nmi_reset_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_nmi_reset_timer_tb;
  localparam int CW   = 3;
  localparam int DV   = 4;
  localparam int HALF = 2;
  localparam int PER  = 2 * HALF * DV;
  localparam int TMO  = (1 << CW) * PER;
  localparam logic [17:0] CTL = wdnr_pkg::CTL_ADDR;
  localparam logic [17:0] ST  = wdnr_pkg::ST_ADDR;

  logic        clk = 1'b0, nrst_tb = 1'b0, osc = 1'b0, osc_run = 1'b1;
  logic        rd = 1'b0, wr = 1'b0;
  logic [17:0] addr = 18'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  be = 4'h0, run;
  logic        waitreq, nmi, cpurst, sys_nrst;
  logic [15:0] nmi_cnt, rst_cnt, n0;
  int          osc_cnt = 0, mismatches = 0, n_checks = 0, c, gap;

  wdnr_top #(.CNT_W(CW), .DIV(DV)) dut_u (
    .i_ref_clk(clk), .i_nrst(nrst_tb & sys_nrst), .i_low_speed_osc(osc),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .o_nmi(nmi), .o_cpu_reset(cpurst));
  wdnr_cpu_model cpu_u (
    .i_ref_clk(clk), .i_nmi(nmi), .i_cpu_reset(cpurst), .o_sys_nrst(sys_nrst),
    .o_nmi_cnt(nmi_cnt), .o_rst_cnt(rst_cnt));

  // ****************************************
  // Clock, slow oscillator and watchdog
  // ****************************************
  always #2 clk = ~clk;

  // Slow oscillator; stands still while sleeping
  always @(posedge clk)
  begin
    if (osc_run)
    begin
      osc_cnt <= (osc_cnt == HALF - 1) ? 0 : osc_cnt + 1;
      if (osc_cnt == HALF - 1)
        osc <= ~osc;
    end
  end

  // Cut a hang short
  initial
  begin
    #50000;
    mismatches++;
    print_verdict();
  end

  // ****************************************
  // Tasks and expectations
  // ****************************************
  function automatic logic [31:0] ctl_val(input logic [3:0] r);
    return {28'h0, r};
  endfunction

  function automatic logic [31:0] st_val(input logic m, input logic o);
    return {30'h0, m, o};
  endfunction

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_time(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t wait %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // One Avalon transfer: hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] v,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= {24'h0, v};
    be <= b;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    check_time(n, 2, 2);
  endtask

  // Wait for an NMI or reset pulse, bounded
  task automatic wait_pulse(input logic rst_sel, input int max, output int cyc);
    logic [15:0] c0;
    c0 = rst_sel ? rst_cnt : nmi_cnt;
    cyc = 0;
    while ((rst_sel ? rst_cnt : nmi_cnt) === c0 && cyc < max)
    begin
      @(posedge clk);
      cyc++;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    c = $urandom(32'h62d93890);
    repeat (2) @(posedge clk);
    nrst_tb <= 1'b1;
    // Reset values, unmapped place, masked write, stopped timer
    bus(0, CTL, 8'h0, 4'hf, d);
    check_reg(d, ctl_val(4'ha));
    bus(0, ST, 8'h0, 4'hf, d);
    check_reg(d, st_val(0, 0));
    bus(0, 18'h0, 8'h0, 4'hf, d);
    check_reg(d, 32'h0);
    bus(1, CTL, 8'h05, 4'he, d);
    bus(0, CTL, 8'h0, 4'hf, d);
    check_reg(d, ctl_val(4'ha));
    wait_pulse(0, 2 * TMO, c);
    check_time(c, 2 * TMO, 2 * TMO);
    $display("test reset_values done");
    // Start with restart, let it overflow into an NMI
    run = 4'($urandom % 16);
    if (run == 4'ha)
      run = 4'h5;
    bus(1, CTL, {4'h1, run}, 4'hf, d);
    wait_pulse(0, 2 * TMO, c);
    check_time(c, TMO - PER - 2, TMO + 8);
    check_reg({16'h0, rst_cnt}, 32'h0);
    bus(0, ST, 8'h0, 4'hf, d);
    check_reg(d, st_val(0, 1));
    bus(0, CTL, 8'h0, 4'hf, d);
    check_reg(d, ctl_val(run));
    bus(1, CTL, {4'h1, run}, 4'hf, d);
    bus(0, ST, 8'h0, 4'hf, d);
    check_reg(d, st_val(0, 0));
    $display("test timeout_nmi done");
    repeat (6)
    begin
      gap = 40 + int'($urandom % 60);
      wait_pulse(0, gap, c);
      check_time(c, gap, gap);
      bus(1, CTL, {4'h1, run}, 4'hf, d);
    end
    $display("test periodic_restart done");
    // Stop keeps the count; start without restart fires early
    repeat (6 * PER) @(posedge clk);
    bus(1, CTL, 8'h0a, 4'hf, d);
    wait_pulse(0, 2 * TMO, c);
    check_time(c, 2 * TMO, 2 * TMO);
    bus(1, CTL, {4'h0, run}, 4'hf, d);
    wait_pulse(0, 2 * TMO, c);
    check_time(c, 0, 3 * PER + 8);
    bus(1, CTL, {4'h1, run}, 4'hf, d);
    $display("test stop_keeps_count done");
    // Sleep: oscillator stands still, count holds
    repeat (2 * PER) @(posedge clk);
    osc_run <= 1'b0;
    wait_pulse(0, 300, c);
    check_time(c, 300, 300);
    osc_run <= 1'b1;
    wait_pulse(0, 2 * TMO, c);
    check_time(c, 5 * PER - 4, TMO + 8);
    bus(1, CTL, {4'h1, run}, 4'hf, d);
    $display("test sleep_hold done");
    // Reset mode: overflow resets the chip, which clears status
    bus(1, ST, 8'h03, 4'hf, d);
    bus(0, ST, 8'h0, 4'hf, d);
    check_reg(d, st_val(1, 0));
    n0 = nmi_cnt;
    bus(1, CTL, {4'h1, run}, 4'hf, d);
    wait_pulse(1, 2 * TMO, c);
    check_time(c, TMO - PER - 2, TMO + 8);
    check_reg({16'h0, nmi_cnt}, {16'h0, n0});
    repeat (8) @(posedge clk);
    bus(0, ST, 8'h0, 4'hf, d);
    check_reg(d, st_val(0, 0));
    bus(0, CTL, 8'h0, 4'hf, d);
    check_reg(d, ctl_val(4'ha));
    $display("test reset_mode done");
    print_verdict();
  end
endmodule // watchdog_nmi_reset_timer_tb
`default_nettype wire
